// ### ixw_pkg.sv
package ixw_pkg;

  // instruction word width and index register width
  localparam int unsigned INSTR_W = 10;
  localparam int unsigned INDEX_W = 4;

  // opcodes of the four handled instructions plus watchdog restart
  localparam logic [INSTR_W-1:0] OP_DECREMENT_INDEX  = 10'h017;
  localparam logic [INSTR_W-1:0] OP_INTERRUPT_MASK   = 10'h004;
  localparam logic [INSTR_W-1:0] OP_INTERRUPT_UNMASK = 10'h005;
  localparam logic [INSTR_W-1:0] OP_WATCHDOG_ARM     = 10'h29C;
  localparam logic [INSTR_W-1:0] OP_WATCHDOG_RESTART = 10'h3FE;

  // index value that marks a wrap from zero
  localparam logic [INDEX_W-1:0] INDEX_WRAP = 4'hF;
  localparam logic [INDEX_W-1:0] INDEX_ONE  = 4'h1;

  // values after reset
  localparam logic [INDEX_W-1:0] INDEX_RST   = 4'h0;
  localparam logic               GATE_RST    = 1'b0;
  localparam logic               ACCEPT_RST  = 1'b0;
  localparam logic               ARMED_RST   = 1'b0;
  localparam logic               STOPPED_RST = 1'b0;

  // instruction cycles between a gate change and its effect
  localparam int unsigned GATE_DELAY_CYC = 1;

  typedef enum logic [1:0] {
    IXW_RUN,
    IXW_SKIP
  } ixw_mode_e;

  typedef struct packed {
    ixw_mode_e          mode;
    logic [INDEX_W-1:0] index;
    logic               gate;
    logic               accept;
    logic               armed;
    logic               stopped;
    logic               restart;
    logic               skipped;
    logic               done;
    logic               skip;
  } ixw_state_s;

endpackage

// ### ixw_dec_if.sv
`timescale 1ns/100ps
interface ixw_dec_if;
  logic [ixw_pkg::INSTR_W-1:0] word;
  logic                        dec_index;
  logic                        dec_mask;
  logic                        dec_unmask;
  logic                        dec_arm;
  logic                        dec_restart;

  modport decoder (
    input  word,
    output dec_index,
    output dec_mask,
    output dec_unmask,
    output dec_arm,
    output dec_restart
  );

  modport core (
    output word,
    input  dec_index,
    input  dec_mask,
    input  dec_unmask,
    input  dec_arm,
    input  dec_restart
  );
endinterface

// ### ixw_decode.sv
`timescale 1ns/100ps
module ixw_decode (
  ixw_dec_if.decoder dec
);

  // full ten-bit compare, so no partial match can fire an operation
  assign dec.dec_index   = (dec.word == ixw_pkg::OP_DECREMENT_INDEX);
  assign dec.dec_mask    = (dec.word == ixw_pkg::OP_INTERRUPT_MASK);
  assign dec.dec_unmask  = (dec.word == ixw_pkg::OP_INTERRUPT_UNMASK);
  assign dec.dec_arm     = (dec.word == ixw_pkg::OP_WATCHDOG_ARM);
  assign dec.dec_restart = (dec.word == ixw_pkg::OP_WATCHDOG_RESTART);

endmodule

// ### ixw_exec.sv
`timescale 1ns/100ps
// What this block does
// - decrement index; skip next when it wraps to 15
// - mask opcode clears the interrupt gate flag
// - masking takes effect one machine cycle later
// - unmask opcode sets the interrupt gate flag
// - unmasking takes effect only after a delay
// - arm opcode only latches permission to stop watchdog
// - restart after arm stops the watchdog
module ixw_exec (
  input  wire logic                        clk_sys,
  input  wire logic                        arst_n,
  input  wire logic                        instr_valid,
  input  wire logic [ixw_pkg::INSTR_W-1:0] instr_word,
  input  wire logic                        index_load,
  input  wire logic [ixw_pkg::INDEX_W-1:0] index_load_val,
  output logic      [ixw_pkg::INDEX_W-1:0] index_q,
  output logic                             skip_pending_q,
  output logic                             instr_skipped_q,
  output logic                             instr_done_q,
  output logic                             irq_gate_flag_q,
  output logic                             irq_accept_en_q,
  output logic                             wdt_stop_armed_q,
  output logic                             wdt_restart_q,
  output logic                             wdt_stopped_q
);

  // the whole execution state lives in one packed struct register
  ixw_pkg::ixw_state_s             state_q;
  ixw_pkg::ixw_state_s             state_d;

  // qualified strobes: a word acts only when taken and not skipped
  logic                            executing;
  logic                            run_index;
  logic                            run_mask;
  logic                            run_unmask;
  logic                            run_arm;
  logic                            run_restart;
  logic                            load_index;

  // decrement datapath and its wrap test
  logic [ixw_pkg::INDEX_W-1:0]     index_dec;
  logic [ixw_pkg::INDEX_W-1:0]     index_borrow;
  logic                            index_wraps;

  // opcode decode sits in its own module behind the decode interface
  ixw_dec_if dec_bus ();

  // decode is pure combinational; the word is taken on instr_valid
  assign dec_bus.word = instr_word;

  ixw_decode u_decode (
    .dec (dec_bus.decoder)
  );

  // a skipped word still uses its instruction cycle but does nothing;
  // every opcode strobe below is gated by this one term; the index load is not
  assign executing = instr_valid && (state_q.mode == ixw_pkg::IXW_RUN);

  // one strobe per handled opcode, each gated by a running word
  assign run_index   = executing && dec_bus.dec_index;
  assign run_mask    = executing && dec_bus.dec_mask;
  assign run_unmask  = executing && dec_bus.dec_unmask;
  assign run_arm     = executing && dec_bus.dec_arm;
  assign run_restart = executing && dec_bus.dec_restart;

  // the decrement owns the index in its cycle, so a load then is dropped
  assign load_index = index_load && !run_index;

  // one full subtractor per index bit; the borrow ripples upward and
  // the last one is dropped, so zero minus one wraps round to fifteen
  assign index_borrow[0] = 1'b0;

  for (genvar b = 0; b < ixw_pkg::INDEX_W; b++)
  begin : g_index_bit
    assign index_dec[b] = state_q.index[b] ^ ixw_pkg::INDEX_ONE[b] ^
                          index_borrow[b];
    if (b < ixw_pkg::INDEX_W - 1)
    begin : g_borrow
      assign index_borrow[b+1] =
        (!state_q.index[b] && ixw_pkg::INDEX_ONE[b]) ||
        (!(state_q.index[b] ^ ixw_pkg::INDEX_ONE[b]) && index_borrow[b]);
    end
  end

  // wrap test on the result itself, so it reads as fifteen after a step
  assign index_wraps = (index_dec == ixw_pkg::INDEX_WRAP);

  // next state, one field group at a time; a field that no group
  // touches simply keeps its held value
  always_comb
  begin
    state_d         = state_q;

    // pulses drop back to zero unless a taken word raises them
    state_d.restart = 1'b0;
    state_d.skipped = 1'b0;
    state_d.done    = 1'b0;

    // index: a decrement wins over a load from other instructions
    if (run_index)
    begin
      state_d.index = index_dec;
    end
    else if (load_index)
    begin
      // the load is the only other writer of the index
      state_d.index = index_load_val;
    end

    // skip sequencing: a wrap sets it, the next taken word clears it
    case (state_q.mode)
      ixw_pkg::IXW_RUN:
      begin
        // only a decrement that wraps asks for a skip
        if (run_index && index_wraps)
        begin
          state_d.mode = ixw_pkg::IXW_SKIP;
        end
      end
      ixw_pkg::IXW_SKIP:
      begin
        if (instr_valid)
        begin
          // the word after a wrap is discarded entirely
          state_d.mode    = ixw_pkg::IXW_RUN;
          state_d.skipped = 1'b1;
        end
      end
      default:
      begin
        // an unused mode code falls back to running
        state_d.mode = ixw_pkg::IXW_RUN;
      end
    endcase

    // registered copy of the skip state, so its output needs no gate;
    // it always moves in step with the mode field
    state_d.skip = (state_d.mode == ixw_pkg::IXW_SKIP);

    // every taken word, skipped or not, is one cycle and one pulse;
    // unknown opcodes do nothing else but still move accept along
    if (instr_valid)
    begin
      // accept follows the gate value held before this cycle, so a
      // change reaches interrupt acceptance one machine cycle later
      state_d.accept = state_q.gate;
      state_d.done   = 1'b1;
    end

    // interrupt gate: mask clears it, unmask sets it; the two are
    // distinct words, so at most one of them fires in a cycle
    if (run_mask)
    begin
      state_d.gate = 1'b0;
    end
    if (run_unmask)
    begin
      state_d.gate = 1'b1;
    end

    // arming is sticky; it only permits a later restart to stop
    if (run_arm)
    begin
      state_d.armed = 1'b1;
    end

    // restart always pulses; it stops the watchdog only once armed,
    // and the stop then holds until reset
    if (run_restart)
    begin
      state_d.restart = 1'b1;
      if (state_q.armed)
      begin
        state_d.stopped = 1'b1;
      end
    end
  end

  // single state register, constants only under reset
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q.mode    <= ixw_pkg::IXW_RUN;
      state_q.index   <= ixw_pkg::INDEX_RST;
      state_q.gate    <= ixw_pkg::GATE_RST;
      state_q.accept  <= ixw_pkg::ACCEPT_RST;
      state_q.armed   <= ixw_pkg::ARMED_RST;
      state_q.stopped <= ixw_pkg::STOPPED_RST;
      state_q.restart <= 1'b0;
      state_q.skipped <= 1'b0;
      state_q.done    <= 1'b0;
      state_q.skip    <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // every output comes straight from a state flop; the block has no
  // carry output, so none of these opcodes can ever disturb a carry

  // index register and skip sequencing
  assign index_q          = state_q.index;
  assign skip_pending_q   = state_q.skip;
  assign instr_skipped_q  = state_q.skipped;

  // one-cycle pulse per taken word
  assign instr_done_q     = state_q.done;

  // interrupt gate and the acceptance that trails it by one word
  assign irq_gate_flag_q  = state_q.gate;
  assign irq_accept_en_q  = state_q.accept;

  // watchdog arm, restart pulse and sticky stop state
  assign wdt_stop_armed_q = state_q.armed;
  assign wdt_restart_q    = state_q.restart;
  assign wdt_stopped_q    = state_q.stopped;

endmodule

// ### ixw_exec_sva.sv
`timescale 1ns/100ps
module ixw_exec_sva (
  input wire logic       clk_sys,
  input wire logic       arst_n,
  input wire logic       instr_valid,
  input wire logic [9:0] instr_word,
  input wire logic       index_load,
  input wire logic [3:0] index_load_val,
  input wire logic [3:0] index_q,
  input wire logic       skip_pending_q,
  input wire logic       instr_skipped_q,
  input wire logic       instr_done_q,
  input wire logic       irq_gate_flag_q,
  input wire logic       irq_accept_en_q,
  input wire logic       wdt_stop_armed_q,
  input wire logic       wdt_restart_q,
  input wire logic       wdt_stopped_q
);
  // a word that really executes, not one eaten by a skip
  wire tk = instr_valid && !skip_pending_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  a_dec_sub: assert property (tk && instr_word == 10'h017 |=>
    index_q == $past(index_q) - 4'h1) else $error("index not decremented");
  a_dec_wrap: assert property (tk && instr_word == 10'h017 &&
    index_q == 4'h0 |=> skip_pending_q) else $error("wrap gave no skip");
  a_skip_eats: assert property (instr_valid && skip_pending_q |=>
    instr_skipped_q && !skip_pending_q) else $error("skip not applied");
  a_mask_gate: assert property (tk && instr_word == 10'h004 |=>
    !irq_gate_flag_q) else $error("mask left gate set");
  a_accept_lag: assert property (tk |=>
    irq_accept_en_q == $past(irq_gate_flag_q)) else $error("accept lag");
  a_unmask_gate: assert property (tk && instr_word == 10'h005 |=>
    irq_gate_flag_q) else $error("unmask left gate clear");
  a_arm_only: assert property (tk && instr_word == 10'h29C |=>
    wdt_stop_armed_q && $stable(wdt_stopped_q)) else $error("arm wrong");
  a_restart_stop: assert property (tk && instr_word == 10'h3FE &&
    wdt_stop_armed_q |=> wdt_stopped_q) else $error("watchdog not stopped");
  a_done_once: assert property (tk |=> instr_done_q ##1
    (instr_done_q == $past(instr_valid))) else $error("done pulse wrong");
endmodule
bind ixw_exec ixw_exec_sva chk_u (.clk_sys(clk_sys), .arst_n(arst_n),
  .instr_valid(instr_valid), .instr_word(instr_word),
  .index_load(index_load), .index_load_val(index_load_val),
  .index_q(index_q), .skip_pending_q(skip_pending_q),
  .instr_skipped_q(instr_skipped_q), .instr_done_q(instr_done_q),
  .irq_gate_flag_q(irq_gate_flag_q), .irq_accept_en_q(irq_accept_en_q),
  .wdt_stop_armed_q(wdt_stop_armed_q), .wdt_restart_q(wdt_restart_q),
  .wdt_stopped_q(wdt_stopped_q));

// ### ixw_prog_mem.sv
`timescale 1ns/100ps
module ixw_prog_mem (
  input  wire logic [3:0] addr,
  output logic      [9:0] word
);
  // fixed program; empty places hold a word that decodes to nothing
  always_comb
  begin
    case (addr)
      4'h0, 4'h3: word = 10'h017;
      4'h1, 4'h4: word = 10'h005;
      4'h5:       word = 10'h004;
      4'h7, 4'h9: word = 10'h3FE;
      4'h8:       word = 10'h29C;
      default:    word = 10'h000;
    endcase
  end
endmodule

// ### testbench.sv
`timescale 1ns/100ps
module testbench;
  logic       clk_sys = 0, arst_n = 0, instr_valid = 0, index_load = 0;
  logic [3:0] index_load_val = 4'h5, pc = 4'h0, index_q;
  logic [9:0] instr_word;
  logic       skip_pending_q, instr_skipped_q, instr_done_q, irq_gate_flag_q;
  logic       irq_accept_en_q, wdt_stop_armed_q, wdt_restart_q, wdt_stopped_q;
  int         n_mismatch = 0, n_tests = 0;
  ixw_prog_mem mem_u (.addr(pc), .word(instr_word));
  ixw_exec dut_u (.clk_sys(clk_sys), .arst_n(arst_n),
    .instr_valid(instr_valid), .instr_word(instr_word),
    .index_load(index_load), .index_load_val(index_load_val),
    .index_q(index_q), .skip_pending_q(skip_pending_q),
    .instr_skipped_q(instr_skipped_q), .instr_done_q(instr_done_q),
    .irq_gate_flag_q(irq_gate_flag_q), .irq_accept_en_q(irq_accept_en_q),
    .wdt_stop_armed_q(wdt_stop_armed_q), .wdt_restart_q(wdt_restart_q),
    .wdt_stopped_q(wdt_stopped_q));
  // free-running clock
  always #5 clk_sys = ~clk_sys;
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      n_mismatch++;
    end
  endtask
  // one word from program memory, taken at one edge
  task automatic step(input logic ld);
    @(posedge clk_sys);
    #1 instr_valid = 1'b1;
    index_load = ld;
    @(posedge clk_sys);
    #1 instr_valid = 1'b0;
    index_load = 1'b0;
    pc = pc + 4'h1;
  endtask
  task automatic t_wrap;
    step(0);
    chk(index_q, 4'hF);
    chk(skip_pending_q, 1'b1);
    chk(instr_done_q, 1'b1);
    step(0);
    chk(instr_skipped_q, 1'b1);
    chk(irq_gate_flag_q, 1'b0);
    step(1);
    step(0);
    chk(index_q, 4'h4);
    chk(skip_pending_q, 1'b0);
    $display("t_wrap finished");
  endtask
  task automatic t_gate;
    step(0);
    chk({irq_gate_flag_q, irq_accept_en_q}, 4'h2);
    step(0);
    chk({irq_gate_flag_q, irq_accept_en_q}, 4'h1);
    step(0);
    chk(irq_accept_en_q, 1'b0);
    $display("t_gate finished");
  endtask
  task automatic t_wdt;
    step(0);
    chk({wdt_restart_q, wdt_stopped_q}, 4'h2);
    step(0);
    chk({wdt_stop_armed_q, wdt_stopped_q}, 4'h2);
    step(0);
    chk({wdt_restart_q, wdt_stopped_q}, 4'h3);
    $display("t_wdt finished");
  endtask
  // reset in mid-run clears the sticky watchdog and gate state
  task automatic t_reset;
    @(posedge clk_sys);
    #1 arst_n = 1'b0;
    #1 chk({wdt_stop_armed_q, wdt_stopped_q, wdt_restart_q}, 4'h0);
    chk({irq_gate_flag_q, irq_accept_en_q, skip_pending_q}, 4'h0);
    chk(index_q, 4'h0);
    @(posedge clk_sys);
    #1 arst_n = 1'b1;
    $display("t_reset finished");
  endtask
  task automatic give_verdict;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // about 25 cycles of work; a hang is cut well after that
  initial
  begin
    #3000;
    n_mismatch++;
    give_verdict();
  end
  // reset, then the scenarios in program order
  initial
  begin
    repeat (3) @(posedge clk_sys);
    #1 arst_n = 1'b1;
    t_wrap();
    t_gate();
    t_wdt();
    t_reset();
    give_verdict();
  end
endmodule
